/* File: cc_timing_pkg.sv */
// Shared constants and types for the contact-closure channel timing block.
`default_nettype none
package cc_timing_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 50;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int PULSE_MS = 125;
    localparam int PULSE_TICKS = (PULSE_MS + TICK_MS - 1) / TICK_MS;
    localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
    localparam int DELAY_MAX_S = 31;
    localparam int EXTN_MAX_HALF_S = 15;
    localparam int HOLD_MAX_STEPS = 15;
    localparam int TICKS_PER_S = 1000 / TICK_MS;
    localparam int TICKS_PER_HALF_S = 500 / TICK_MS;
    localparam int NUM_CH = 4;
    localparam int NUM_SENSORS = 8;
    localparam int TW = 10;
    localparam logic [NUM_CH-1:0] RESET_CH_ENABLE = 4'h3;
    localparam logic [NUM_CH-1:0] RESET_CH_PRESENCE = 4'h0;
    localparam int REG_CH_ENABLE = 0;
    localparam int REG_CH_MODE = 1;
    localparam int REG_CH_MOD_BASE = 2;
    localparam int REG_SENS_BASE = 6;
    localparam int REG_STATUS = 14;
    localparam int REG_IDENT = 15;
    localparam int REG_DISP = 16;

    typedef enum logic [1:0] {
        MOD_NONE = 2'b00,
        MOD_DELAY = 2'b01,
        MOD_EXTN = 2'b10
    } modifier_t;

    // Per-channel configuration.
    typedef struct packed {
        modifier_t kind;
        logic [4:0] value;
    } ch_mod_t;

    // Per-sensor mapping: target shelf, slot, channel mask, holdover, own ext, own delay.
    typedef struct packed {
        logic [1:0] shelf;
        logic [3:0] slot;
        logic [3:0] ch_mask;
        logic [3:0] hold;
        logic [3:0] ext;
        logic [4:0] delay;
    } sensor_map_t;

    // Decoded card identity.
    typedef struct packed {
        logic [1:0] shelf;
        logic ctrl_second;
        logic [3:0] slot;
    } card_id_t;
endpackage
`default_nettype wire

/* File: cc_tick_gen.sv */
// Free-running 50 ms tick generator.
`default_nettype none
module cc_tick_gen #(
    parameter int CYCLES = cc_timing_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Tick.
    output logic tick_out
);
    import cc_timing_pkg::*;
    initial begin
        if (CYCLES < 2) $error("tick period too short");
    end
    logic [23:0] count;

    // Count up one tick period and pulse at wrap.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= 24'h000000;
            tick_out <= 1'b0;
        end else if (count == 24'(CYCLES - 1)) begin
            count <= 24'h000000;
            tick_out <= 1'b1;
        end else begin
            count <= count + 24'h000001;
            tick_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: cc_channel.sv */
// One contact-closure channel: pulse, presence, delay and extension timing.
`default_nettype none
module cc_channel (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Timing and configuration.
    input wire logic tick_in,
    input wire logic enable_in,
    input wire logic presence_in,
    input wire logic [cc_timing_pkg::TW-1:0] delay_ticks_in,
    input wire logic [cc_timing_pkg::TW-1:0] extn_ticks_in,
    // Detection.
    input wire logic active_in,
    input wire logic lead_in,
    // Output.
    output logic closed_out
);
    import cc_timing_pkg::*;
    logic [21:0] pulse_cnt;
    logic [TW-1:0] delay_cnt;
    logic [TW-1:0] extn_cnt;
    logic det_closed;

    // Pulse mode: each leading edge arms a closure counted in clock cycles.
    // The pulse is not a whole number of ticks, so it cannot use the common tick.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_cnt <= '0;
        end else if (!enable_in || presence_in) begin
            pulse_cnt <= '0;
        end else if (lead_in) begin
            pulse_cnt <= 22'(PULSE_CYCLES);
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 22'h000001;
        end
    end

    // Presence delay: closure only after detection has lasted the delay.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            delay_cnt <= '0;
            det_closed <= 1'b0;
        end else if (!active_in || !enable_in || !presence_in) begin
            delay_cnt <= '0;
            det_closed <= 1'b0;
        end else if (delay_cnt >= delay_ticks_in) begin
            det_closed <= 1'b1;
        end else if (tick_in) begin
            delay_cnt <= delay_cnt + 1'b1;
        end
    end

    // Extension keeps closure after detection ends, only if it had closed.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            extn_cnt <= '0;
        end else if (!enable_in || !presence_in) begin
            extn_cnt <= '0;
        end else if (det_closed) begin
            extn_cnt <= extn_ticks_in;
        end else if (tick_in && extn_cnt != '0) begin
            extn_cnt <= extn_cnt - 1'b1;
        end
    end

    // Disabled channel stays open.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            closed_out <= 1'b0;
        end else begin
            closed_out <= enable_in && (presence_in ? (det_closed || extn_cnt != '0)
                                                    : pulse_cnt != '0);
        end
    end
endmodule
`default_nettype wire

/* File: cc_channel_timing.sv */
// Four-channel contact-closure timing with sensor mapping and card identity.
//
// Function
// - Disabled channel holds contact and status outputs open always.
// - Enabled channel acts on events from sensors mapped to it.
// - After reset channels one and two are enabled, others disabled.
// - Pulse mode closes contact 0.125 s per leading edge.
// - Presence mode holds contact closed while detection is active.
// - Every channel defaults to pulse mode.
// - Delay defers closure; detection ending earlier never closes.
// - Delay setting covers 0 to 31 whole seconds.
// - Extension prolongs closure 0 to 7.5 s in half seconds.
// - Delay and extension do nothing in pulse mode.
// - Per-sensor holdover lengthens activation by 0 to 0.75 s.
// - Per-sensor delay and extension apply only to that sensor's events.
// - Slot display shows slot number on the four channel indicators.
// - Shelf decoded from switch positions one and two only.
// - Controller type from position three alone.
// - Slot decoded from the second switch bank.
// - Holdover steps are 0.05 s.
`default_nettype none
module cc_channel_timing #(
    parameter int NSENS = cc_timing_pkg::NUM_SENSORS
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port.
    input wire logic [4:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Detection events from the access point, one level per sensor.
    input wire logic [NSENS-1:0] detect_in,
    // Board switch banks.
    input wire logic [3:0] shelf_type_switch_bank_in,
    input wire logic [3:0] slot_switch_bank_in,
    // Outputs.
    output logic [cc_timing_pkg::NUM_CH-1:0] contact_out,
    output logic [cc_timing_pkg::NUM_CH-1:0] status_out,
    output logic [cc_timing_pkg::NUM_CH-1:0] indicator_out,
    output logic controller_type_second_out
);
    import cc_timing_pkg::*;
    initial begin
        if (NSENS < 1 || NSENS > 8) $error("sensor count must be 1 to 8");
    end

    logic tick;
    logic [NUM_CH-1:0] ch_enable;
    logic [NUM_CH-1:0] ch_presence;
    logic slot_display;
    ch_mod_t ch_mod [NUM_CH];
    sensor_map_t smap [NSENS];
    logic [NSENS-1:0] det_s1;
    logic [NSENS-1:0] det_s2;
    logic [NSENS-1:0] det_prev;
    logic [3:0] sw1_s1;
    logic [3:0] sw1_s2;
    logic [3:0] sw2_s1;
    logic [3:0] sw2_s2;
    card_id_t card_id;
    logic [TW-1:0] hold_cnt [NSENS];
    logic [TW-1:0] sdly_cnt [NSENS];
    logic [NSENS-1:0] sens_on;
    logic [NUM_CH-1:0] ch_active;
    logic [NUM_CH-1:0] ch_lead;
    logic [NUM_CH-1:0] ch_closed;
    logic [TW-1:0] ch_delay_ticks [NUM_CH];
    logic [TW-1:0] ch_extn_ticks [NUM_CH];

    // Decode card identity from synchronised switch banks.
    function automatic card_id_t decode_id(input logic [3:0] sw1, input logic [3:0] sw2);
        card_id_t id;
        id.shelf = sw1[1:0];
        id.ctrl_second = sw1[2];
        id.slot = sw2;
        return id;
    endfunction

    // Convert a setting count into ticks per step.
    function automatic logic [TW-1:0] to_ticks(input logic [4:0] v, input int per);
        return TW'(32'(v) * per);
    endfunction

    // Does a sensor mapping address this card?
    function automatic logic maps_here(input sensor_map_t m, input card_id_t id);
        return (m.shelf == id.shelf) && (m.slot == id.slot);
    endfunction

    cc_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tick_out(tick)
    );

    // Two-stage synchronisers for pins.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            det_s1 <= '0;
            det_s2 <= '0;
            det_prev <= '0;
            sw1_s1 <= 4'h0;
            sw1_s2 <= 4'h0;
            sw2_s1 <= 4'h0;
            sw2_s2 <= 4'h0;
        end else begin
            det_s1 <= detect_in;
            det_s2 <= det_s1;
            det_prev <= det_s2;
            sw1_s1 <= shelf_type_switch_bank_in;
            sw1_s2 <= sw1_s1;
            sw2_s1 <= slot_switch_bank_in;
            sw2_s2 <= sw2_s1;
        end
    end

    // Registered card identity.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            card_id <= '0;
        end else begin
            card_id <= decode_id(sw1_s2, sw2_s2);
        end
    end

    // Channel configuration registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ch_enable <= RESET_CH_ENABLE;
            ch_presence <= RESET_CH_PRESENCE;
            slot_display <= 1'b0;
            for (int c = 0; c < NUM_CH; c++) begin
                ch_mod[c] <= '0;
            end
        end else if (wr_in) begin
            if (addr_in == 5'(REG_CH_ENABLE)) begin
                ch_enable <= wdata_in[NUM_CH-1:0];
            end
            if (addr_in == 5'(REG_CH_MODE)) begin
                ch_presence <= wdata_in[NUM_CH-1:0];
            end
            if (addr_in == 5'(REG_DISP)) begin
                slot_display <= wdata_in[0];
            end
            for (int c = 0; c < NUM_CH; c++) begin
                if (addr_in == 5'(REG_CH_MOD_BASE + c)) begin
                    ch_mod[c].kind <= modifier_t'(wdata_in[6:5]);
                    ch_mod[c].value <= (wdata_in[6:5] == MOD_EXTN && wdata_in[4]) ?
                        5'h0F : wdata_in[4:0];
                end
            end
        end
    end

    // Sensor mapping registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int s = 0; s < NSENS; s++) begin
                smap[s] <= '0;
            end
        end else if (wr_in) begin
            for (int s = 0; s < NSENS; s++) begin
                if (addr_in == 5'(REG_SENS_BASE + s)) begin
                    smap[s] <= sensor_map_t'(wdata_in[22:0]);
                    if (wdata_in[12:9] > 4'(HOLD_MAX_STEPS)) begin
                        smap[s].hold <= 4'(HOLD_MAX_STEPS);
                    end
                end
            end
        end
    end

    // Per-sensor own delay and holdover plus own extension.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int s = 0; s < NSENS; s++) begin
                hold_cnt[s] <= '0;
                sdly_cnt[s] <= '0;
                sens_on[s] <= 1'b0;
            end
        end else begin
            for (int s = 0; s < NSENS; s++) begin
                if (!det_s2[s]) begin
                    sdly_cnt[s] <= '0;
                end else if (tick && sdly_cnt[s] < to_ticks(smap[s].delay, TICKS_PER_S)) begin
                    sdly_cnt[s] <= sdly_cnt[s] + 1'b1;
                end
                if (det_s2[s] && sdly_cnt[s] >= to_ticks(smap[s].delay, TICKS_PER_S)) begin
                    sens_on[s] <= 1'b1;
                    hold_cnt[s] <= to_ticks(5'(smap[s].hold), 1)
                        + to_ticks(5'(smap[s].ext), TICKS_PER_HALF_S);
                end else if (hold_cnt[s] != '0) begin
                    sens_on[s] <= 1'b1;
                    if (tick) begin
                        hold_cnt[s] <= hold_cnt[s] - 1'b1;
                    end
                end else begin
                    sens_on[s] <= 1'b0;
                end
            end
        end
    end

    // Gather mapped sensors into channel activity and leading edges.
    always_comb begin
        ch_active = '0;
        ch_lead = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            for (int s = 0; s < NSENS; s++) begin
                if (maps_here(smap[s], card_id) && smap[s].ch_mask[c] && ch_enable[c]) begin
                    ch_active[c] = ch_active[c] | sens_on[s];
                    ch_lead[c] = ch_lead[c] | (det_s2[s] & ~det_prev[s]);
                end
            end
        end
    end

    // Channel modifier values in ticks.
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            ch_delay_ticks[c] = (ch_mod[c].kind == MOD_DELAY) ?
                to_ticks(ch_mod[c].value, TICKS_PER_S) : '0;
            ch_extn_ticks[c] = (ch_mod[c].kind == MOD_EXTN) ?
                to_ticks(ch_mod[c].value, TICKS_PER_HALF_S) : '0;
        end
    end

    // One timing unit per channel.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        cc_channel u_ch (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .tick_in(tick),
            .enable_in(ch_enable[c]),
            .presence_in(ch_presence[c]),
            .delay_ticks_in(ch_delay_ticks[c]),
            .extn_ticks_in(ch_extn_ticks[c]),
            .active_in(ch_active[c]),
            .lead_in(ch_lead[c]),
            .closed_out(ch_closed[c])
        );
    end

    // Outputs: contact and status follow closure; indicators may show the slot.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            contact_out <= '0;
            status_out <= '0;
            indicator_out <= '0;
            controller_type_second_out <= 1'b0;
        end else begin
            contact_out <= ch_closed & ch_enable;
            status_out <= ch_closed & ch_enable;
            indicator_out <= slot_display ? card_id.slot : (ch_closed & ch_enable);
            controller_type_second_out <= card_id.ctrl_second;
        end
    end

    // Read data, valid the cycle after the read strobe.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 32'h00000000;
        end else if (rd_in) begin
            rdata_out <= 32'h00000000;
            if (addr_in == 5'(REG_CH_ENABLE)) rdata_out <= 32'(ch_enable);
            if (addr_in == 5'(REG_CH_MODE)) rdata_out <= 32'(ch_presence);
            if (addr_in == 5'(REG_DISP)) rdata_out <= 32'(slot_display);
            if (addr_in == 5'(REG_STATUS)) rdata_out <= 32'({ch_active, ch_closed});
            if (addr_in == 5'(REG_IDENT)) rdata_out <= 32'(card_id);
            for (int c = 0; c < NUM_CH; c++) begin
                if (addr_in == 5'(REG_CH_MOD_BASE + c)) rdata_out <= 32'(ch_mod[c]);
            end
            for (int s = 0; s < NSENS; s++) begin
                if (addr_in == 5'(REG_SENS_BASE + s)) rdata_out <= 32'(smap[s]);
            end
        end else begin
            rdata_out <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

/* File: cc_channel_timing_sva.sv */
// Assertion checker for the contact-closure channel timing block.
`default_nettype none
module cc_channel_timing_sva #(
    parameter int NSENS = 8
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port.
    input wire logic [4:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    // Detections and switches.
    input wire logic [NSENS-1:0] detect_in,
    input wire logic [3:0] shelf_type_switch_bank_in,
    input wire logic [3:0] slot_switch_bank_in,
    // Outputs.
    input wire logic [3:0] contact_out,
    input wire logic [3:0] status_out,
    input wire logic [3:0] indicator_out,
    input wire logic controller_type_second_out
);
    logic [3:0] en;
    logic disp;
    logic [3:0] settle;
    logic [4:0] since_det;
    logic [3:0] age;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Shadow the enable and display settings and count quiet cycles after any write.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en <= 4'h3;
            disp <= 1'b0;
            settle <= 4'h0;
            age <= 4'h0;
        end else begin
            if (age != 4'hF) age <= age + 4'h1;
            if (wr_in && addr_in == 5'h00) en <= wdata_in[3:0];
            if (wr_in && addr_in == 5'h10) disp <= wdata_in[0];
            if (wr_in) settle <= 4'h0;
            else if (settle != 4'hF) settle <= settle + 4'h1;
        end
    end

    // Count cycles since any sensor last reported a detection.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) since_det <= 5'h1F;
        else if (|detect_in) since_det <= 5'h00;
        else if (since_det != 5'h1F) since_det <= since_det + 5'h01;
    end

    status_match_a: assert property (status_out == contact_out)
        else $error("status output differs from contact output");
    disabled_open_a: assert property (settle > 4'h3 |-> (contact_out & ~en) == 4'h0)
        else $error("disabled channel closed");
    no_phantom_a: assert property ((contact_out & ~$past(contact_out)) != 4'h0 |-> since_det < 5'd12)
        else $error("closure without a detection");
    display_slot_a: assert property ($stable(slot_switch_bank_in)[*6] ##0 (disp && settle > 4'h5)
        |-> indicator_out == slot_switch_bank_in)
        else $error("indicators do not show the slot");
    ident_read_a: assert property (rd_in && addr_in == 5'h0F |=> rdata_out == {25'h0,
        shelf_type_switch_bank_in[1:0], shelf_type_switch_bank_in[2], slot_switch_bank_in})
        else $error("identity read wrong");
    ctrl_type_a: assert property ($stable(shelf_type_switch_bank_in)[*8] ##0 age > 4'h5
        |-> controller_type_second_out == shelf_type_switch_bank_in[2])
        else $error("controller type output wrong");
    rdata_idle_a: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data outside its cycle");
    unmapped_read_a: assert property (rd_in && addr_in > 5'h10 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    reset_open_a: assert property ($rose(rst_n_in) |-> contact_out == 4'h0 && indicator_out == 4'h0)
        else $error("outputs not open after reset");

    cover property (rd_in && addr_in == 5'h0F);
    cover property ($rose(contact_out[1]));
    cover property (disp && settle > 4'h5);
endmodule

bind cc_channel_timing cc_channel_timing_sva #(.NSENS(NSENS)) i_cc_channel_timing_sva (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .detect_in(detect_in),
    .shelf_type_switch_bank_in(shelf_type_switch_bank_in),
    .slot_switch_bank_in(slot_switch_bank_in), .contact_out(contact_out),
    .status_out(status_out), .indicator_out(indicator_out),
    .controller_type_second_out(controller_type_second_out)
);
`default_nettype wire

/* File: cc_access_point_model.sv */
// Behavioural access point that forwards per-sensor detection levels to the card.
`default_nettype none
module cc_access_point_model #(
    parameter int NSENS = 8
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Detections requested by the bench.
    input wire logic [NSENS-1:0] want_in,
    // Detection levels toward the card.
    output logic [NSENS-1:0] detect_out
);
    // Forward each sensor's level one edge later and report nothing while in reset.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) detect_out <= '0;
        else detect_out <= want_in;
    end
endmodule
`default_nettype wire

/* File: cc_channel_timing_tb_top.sv */
// Self-checking testbench for the contact-closure channel timing block.
`default_nettype none
module cc_channel_timing_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cc_timing_pkg::*;

    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [4:0] addr_in = 5'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] want = 8'h00;
    logic [3:0] shelf_sw = 4'hE;
    logic [3:0] slot_sw = 4'h9;
    wire logic [7:0] detect;
    wire logic [31:0] rdata_out;
    wire logic [3:0] contact_out;
    wire logic [3:0] status_out;
    wire logic [3:0] indicator_out;
    wire logic ctrl_out;
    logic [31:0] rv;
    int bad_count = 0;
    int total_checks = 0;

    cc_channel_timing i_cc_channel_timing (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .detect_in(detect), .shelf_type_switch_bank_in(shelf_sw),
        .slot_switch_bank_in(slot_sw), .contact_out(contact_out), .status_out(status_out),
        .indicator_out(indicator_out), .controller_type_second_out(ctrl_out));
    cc_access_point_model i_cc_access_point_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .want_in(want), .detect_out(detect));

    // Free-running 25 MHz clock.
    initial begin
        forever #20 clk_in = ~clk_in;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wr_reg(input int a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a[4:0];
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input int a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a[4:0];
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    // Sensor map word aimed at a shelf, slot and channel mask, no timing extras.
    function automatic logic [31:0] map_word(logic [1:0] sh, logic [3:0] sl, logic [3:0] m);
        return {9'h0, sh, sl, m, 13'h0};
    endfunction

    task automatic t_reset();
        rd_reg(REG_CH_ENABLE, rv);
        chk("enable", rv, 32'h3);
        rd_reg(REG_CH_MODE, rv);
        chk("mode", rv, 32'h0);
        rd_reg(31, rv);
        chk("unmapped", rv, 32'h0);
        chk("contact", {28'h0, contact_out}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_ident();
        rd_reg(REG_IDENT, rv);
        chk("ident", rv, 32'h59);
        chk("ctrl", {31'h0, ctrl_out}, 32'h1);
        $display("test ident done");
    endtask

    task automatic t_display();
        wr_reg(REG_DISP, 32'h1);
        idle(8);
        chk("slot9", {28'h0, indicator_out}, 32'h9);
        slot_sw <= 4'hF;
        idle(8);
        chk("slot15", {28'h0, indicator_out}, 32'hF);
        slot_sw <= 4'h4;
        idle(8);
        chk("slot4", {28'h0, indicator_out}, 32'h4);
        slot_sw <= 4'h9;
        wr_reg(REG_DISP, 32'h0);
        idle(8);
        $display("test display done");
    endtask

    task automatic t_presence();
        wr_reg(REG_SENS_BASE, map_word(2'h2, 4'h9, 4'h3));
        wr_reg(REG_CH_MODE, 32'h2);
        want <= 8'h01;
        idle(20);
        chk("onset", {30'h0, contact_out[1:0]}, 32'h3);
        idle(300);
        chk("held", {30'h0, contact_out[1:0]}, 32'h3);
        want <= 8'h00;
        idle(20);
        chk("release", {31'h0, contact_out[1]}, 32'h0);
        $display("test presence done");
    endtask

    task automatic t_disabled();
        wr_reg(REG_SENS_BASE + 1, map_word(2'h2, 4'h9, 4'h4));
        wr_reg(REG_SENS_BASE + 2, map_word(2'h2, 4'h3, 4'h8));
        wr_reg(REG_CH_MODE, 32'hE);
        wr_reg(REG_CH_ENABLE, 32'hB);
        want <= 8'h06;
        idle(20);
        chk("disabled", {30'h0, contact_out[3:2]}, 32'h0);
        wr_reg(REG_CH_ENABLE, 32'hF);
        idle(20);
        chk("enabled", {31'h0, contact_out[2]}, 32'h1);
        want <= 8'h00;
        idle(20);
        $display("test disabled done");
    endtask

    task automatic t_delay();
        wr_reg(REG_CH_MOD_BASE + 2, 32'h21);
        wr_reg(REG_CH_MOD_BASE + 3, 32'h21);
        wr_reg(REG_CH_MODE, 32'h6);
        wr_reg(REG_SENS_BASE + 3, map_word(2'h2, 4'h9, 4'hC));
        want <= 8'h08;
        idle(100);
        chk("pulse", {31'h0, contact_out[3]}, 32'h1);
        chk("deferred", {31'h0, contact_out[2]}, 32'h0);
        want <= 8'h00;
        idle(100);
        chk("never", {31'h0, contact_out[2]}, 32'h0);
        wr_reg(REG_CH_MOD_BASE, 32'h3F);
        rd_reg(REG_CH_MOD_BASE, rv);
        chk("delay31", rv, 32'h3F);
        wr_reg(REG_CH_MOD_BASE + 1, 32'h5F);
        rd_reg(REG_CH_MOD_BASE + 1, rv);
        chk("extn_clamp", rv, 32'h4F);
        $display("test delay done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 700 cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        $display("watchdog expired");
        wrap_up();
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        idle(10);
        t_reset();
        t_ident();
        t_display();
        t_presence();
        t_disabled();
        t_delay();
        wrap_up();
    end
endmodule
`default_nettype wire
